// ---- fkd_pkg.sv ----
`default_nettype none
package fkd_pkg;
    // key function selection codes, in the order of the setting table
    typedef enum logic [3:0] {
        FKD_FN_OFF,
        FKD_FN_RUN,
        FKD_FN_RESET,
        FKD_FN_RUN_RESET,
        FKD_FN_HOLD,
        FKD_FN_SEGMENT_SKIP_FORWARD,
        FKD_FN_FULL_TUNE_TOGGLE,
        FKD_FN_PARTIAL_TUNE_TOGGLE,
        FKD_FN_ALL_SETS_FULL_TUNE_TOGGLE,
        FKD_FN_ALL_SETS_PARTIAL_TUNE_TOGGLE,
        FKD_FN_ALARM_HOLD_RELEASE,
        FKD_FN_AUTO_MANUAL,
        FKD_FN_MONITOR_ITEM_CYCLE,
        FKD_FN_DIGIT_SHIFT
    } fkd_fn_t;

    // register byte addresses
    localparam logic [7:0] FKD_CFG_ADDR = 8'h00;
    localparam logic [7:0] FKD_STAT_ADDR = 8'h04;
    localparam logic [7:0] FKD_CMD_ADDR = 8'h08;
    // config field positions
    localparam int FKD_CFG_FN_LSB = 0;
    localparam int FKD_CFG_LOCK_BIT = 4;
    localparam int FKD_CFG_HC_BIT = 5;
    // status field positions
    localparam int FKD_ST_RUN_BIT = 0;
    localparam int FKD_ST_HOLD_BIT = 1;
    localparam int FKD_ST_MAN_BIT = 2;
    localparam int FKD_ST_TUNE_BIT = 3;
    localparam int FKD_ST_ITEM_LSB = 4;
    // command bit: software reports tuning finished
    localparam int FKD_CMD_TUNE_DONE_BIT = 0;
    // reset values
    localparam fkd_fn_t FKD_FN_RESET_VAL = FKD_FN_DIGIT_SHIFT;
    localparam logic [2:0] FKD_ITEM_RESET = 3'h0;
    localparam logic [2:0] FKD_ITEM_COUNT = 3'h5;
    // timing: tick period and hold times
    localparam int FKD_CLK_MHZ = 250;
    localparam int FKD_TICK_US = 1000;
    localparam int FKD_RUN_HOLD_MS = 1000;
    localparam int FKD_RESET_HOLD_MS = 2000;
    localparam int FKD_TICK_CYCLES = FKD_TICK_US * FKD_CLK_MHZ;
    localparam int FKD_RUN_HOLD_TICKS = FKD_RUN_HOLD_MS * 1000 / FKD_TICK_US;
    localparam int FKD_RESET_HOLD_TICKS = FKD_RESET_HOLD_MS * 1000 / FKD_TICK_US;
    localparam logic [1:0] FKD_RESP_OKAY = 2'h0;
    localparam logic [1:0] FKD_RESP_SLVERR = 2'h2;

    // one-cycle action pulses toward the controller core
    typedef struct packed {
        logic run;
        logic reset;
        logic hold_toggle;
        logic skip_forward;
        logic tune_start;
        logic tune_cancel;
        logic tune_all_sets;
        logic tune_partial;
        logic alarm_release;
        logic auto_manual;
        logic digit_shift;
        logic item_advance;
    } fkd_act_t;
endpackage
`default_nettype wire

// ---- fkd_tick.sv ----
`default_nettype none
// free-running divider giving one pulse per tick period
module fkd_tick #(
    parameter int CYCLES = 250000
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    logic [31:0] cnt_q; // cycles within the current tick

    // count up through the period, pulse on wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_q == 32'(CYCLES - 1)) begin
            cnt_q <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- fkd_function_key_dispatch.sv ----
`default_nettype none
// Summary of operation
// - function off ignores every press
// - reset needs two seconds held
// - run needs one second held
// - other actions need one second held, except item cycling and digit shift, which act on the press edge
// - monitor mode steps through five items
// - lockout on makes presses do nothing
// - hold mode inverts program hold state
// - skip mode fires one advance
// - tune modes toggle current set tuning
// - all-sets modes toggle tuning every set
// - cancel stops any running tuning variant
// - partial tuning inert under heat-cool control
// - release clears alarm latches one-four, heater
// - auto/manual mode inverts control mode
// - digit shift only while editing
// - default selection is digit shift
module fkd_function_key_dispatch #(
    parameter int TICK_CYCLES = fkd_pkg::FKD_TICK_CYCLES,
    parameter int RUN_TICKS = fkd_pkg::FKD_RUN_HOLD_TICKS,
    parameter int RESET_TICKS = fkd_pkg::FKD_RESET_HOLD_TICKS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    // front-panel key, high while pressed, already debounced
    input wire logic function_key_assign,
    // high while a setting is being edited
    input wire logic editing,
    // axi4-lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // action pulses
    output fkd_pkg::fkd_act_t act,
    // current monitor item slot, 0..4
    output logic [2:0] monitor_item
);
    // reset synchroniser: the rest of the block uses rst_sync_n
    logic rst_meta_q;
    logic rst_sync_n;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // hold time is measured in ticks, not raw cycles
    logic tick;
    fkd_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk(ref_clk),
        .rst_n(rst_sync_n),
        .tick(tick)
    );

    // configuration and state registers
    fkd_pkg::fkd_fn_t fn_q; // key function selection
    logic lockout_q; // function_key_lockout
    logic heat_cool_q; // heating/cooling or floating control in use
    logic running_q; // run (1) or reset (0)
    logic hold_q; // program holding
    logic manual_q; // manual control mode
    logic tune_q; // auto_tuning running

    // press tracking
    logic key_q; // key level one cycle ago
    logic [15:0] held_q; // ticks the key has been down
    logic fired_q; // action already given for this press

    // press edge; release needs no edge because the counter clears on the low level
    wire logic press_rise = function_key_assign && !key_q;

    // key usable only with function on and lockout off
    wire logic key_enabled = !lockout_q && (fn_q != fkd_pkg::FKD_FN_OFF);

    // hold-duration reached thresholds
    wire logic run_due = (held_q >= 16'(RUN_TICKS));
    wire logic reset_due = (held_q >= 16'(RESET_TICKS));

    // tuning selection decode used by several processes
    function automatic logic is_tune(input fkd_pkg::fkd_fn_t f);
        is_tune = (f == fkd_pkg::FKD_FN_FULL_TUNE_TOGGLE) ||
                  (f == fkd_pkg::FKD_FN_PARTIAL_TUNE_TOGGLE) ||
                  (f == fkd_pkg::FKD_FN_ALL_SETS_FULL_TUNE_TOGGLE) ||
                  (f == fkd_pkg::FKD_FN_ALL_SETS_PARTIAL_TUNE_TOGGLE);
    endfunction
    function automatic logic is_partial(input fkd_pkg::fkd_fn_t f);
        is_partial = (f == fkd_pkg::FKD_FN_PARTIAL_TUNE_TOGGLE) ||
                     (f == fkd_pkg::FKD_FN_ALL_SETS_PARTIAL_TUNE_TOGGLE);
    endfunction

    // held-action fire condition: once per press, after the needed time
    logic fire;
    always_comb begin
        fire = 1'b0;
        if (key_enabled && function_key_assign && !fired_q) begin
            unique case (fn_q)
                // run/reset toggle: run needs 1 s, reset needs 2 s
                fkd_pkg::FKD_FN_RUN_RESET: fire = running_q ? reset_due : run_due;
                fkd_pkg::FKD_FN_RESET: fire = reset_due;
                // item cycling and digit shift act on the edge instead
                fkd_pkg::FKD_FN_MONITOR_ITEM_CYCLE,
                fkd_pkg::FKD_FN_DIGIT_SHIFT,
                fkd_pkg::FKD_FN_OFF: fire = 1'b0;
                default: fire = run_due;
            endcase
        end
    end

    // press duration counter, counted in ticks; saturates
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            key_q <= 1'b0;
            held_q <= 16'h0;
        end else begin
            key_q <= function_key_assign;
            if (!function_key_assign) begin
                held_q <= 16'h0; // release before the time throws the press away
            end else if (tick && held_q != 16'hffff) begin
                held_q <= held_q + 16'h1;
            end
        end
    end

    // one action per press: armed on release
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fired_q <= 1'b0;
        end else if (!function_key_assign) begin
            fired_q <= 1'b0;
        end else if (fire || press_rise) begin
            // edge-acting modes also count as fired on the press edge
            fired_q <= fire || (fn_q == fkd_pkg::FKD_FN_MONITOR_ITEM_CYCLE) ||
                       (fn_q == fkd_pkg::FKD_FN_DIGIT_SHIFT);
        end
    end

    // action pulses, registered so outputs come from flops
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            act <= '0;
        end else begin
            act <= '0;
            if (fire) begin
                unique case (fn_q)
                    fkd_pkg::FKD_FN_RUN: act.run <= 1'b1;
                    fkd_pkg::FKD_FN_RESET: act.reset <= 1'b1;
                    fkd_pkg::FKD_FN_RUN_RESET: begin
                        act.run <= !running_q;
                        act.reset <= running_q;
                    end
                    fkd_pkg::FKD_FN_HOLD: act.hold_toggle <= 1'b1;
                    fkd_pkg::FKD_FN_SEGMENT_SKIP_FORWARD: act.skip_forward <= 1'b1;
                    fkd_pkg::FKD_FN_ALARM_HOLD_RELEASE: act.alarm_release <= 1'b1;
                    fkd_pkg::FKD_FN_AUTO_MANUAL: act.auto_manual <= 1'b1;
                    default: begin
                        // partial tuning does nothing under heat-cool control
                        if (is_tune(fn_q) && !(is_partial(fn_q) && heat_cool_q)) begin
                            // cancel applies to whatever variant runs
                            act.tune_cancel <= tune_q;
                            act.tune_start <= !tune_q;
                            act.tune_partial <= is_partial(fn_q) && !tune_q;
                            act.tune_all_sets <= !tune_q && (fn_q == fkd_pkg::FKD_FN_ALL_SETS_FULL_TUNE_TOGGLE ||
                                fn_q == fkd_pkg::FKD_FN_ALL_SETS_PARTIAL_TUNE_TOGGLE);
                        end
                    end
                endcase
            end
            if (key_enabled && press_rise) begin
                act.item_advance <= (fn_q == fkd_pkg::FKD_FN_MONITOR_ITEM_CYCLE);
                act.digit_shift <= (fn_q == fkd_pkg::FKD_FN_DIGIT_SHIFT) && editing;
            end
        end
    end

    // monitor item slot steps 0..4 and wraps
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            monitor_item <= fkd_pkg::FKD_ITEM_RESET;
        end else if (key_enabled && press_rise && fn_q == fkd_pkg::FKD_FN_MONITOR_ITEM_CYCLE) begin
            monitor_item <= (monitor_item == fkd_pkg::FKD_ITEM_COUNT - 3'h1) ?
                fkd_pkg::FKD_ITEM_RESET : monitor_item + 3'h1;
        end
    end

    // controller state images, kept in step with the pulses
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            running_q <= 1'b0;
            hold_q <= 1'b0;
            manual_q <= 1'b0;
        end else begin
            if (act.run) running_q <= 1'b1;
            if (act.reset) running_q <= 1'b0;
            if (act.hold_toggle) hold_q <= !hold_q;
            if (act.auto_manual) manual_q <= !manual_q;
        end
    end

    // tuning flag: key start sets it; key cancel or software done clears it
    logic sw_tune_done;
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tune_q <= 1'b0;
        end else if (act.tune_start) begin
            tune_q <= 1'b1; // set wins over a same-cycle clear
        end else if (act.tune_cancel || sw_tune_done) begin
            tune_q <= 1'b0;
        end
    end

    // axi4-lite write channel: take address and data in either order
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    wire logic do_write = aw_have_q && w_have_q && !s_bvalid;
    assign sw_tune_done = do_write && aw_addr_q == fkd_pkg::FKD_CMD_ADDR && w_strb_q[0] &&
                          w_data_q[fkd_pkg::FKD_CMD_TUNE_DONE_BIT];

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= fkd_pkg::FKD_RESP_OKAY;
        end else begin
            // ready is offered for one cycle, only when the slot is free
            s_awready <= !aw_have_q && s_awvalid && !s_awready;
            s_wready <= !w_have_q && s_wvalid && !s_wready;
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_wdata;
                w_strb_q <= s_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= (aw_addr_q == fkd_pkg::FKD_CFG_ADDR || aw_addr_q == fkd_pkg::FKD_CMD_ADDR) ?
                    fkd_pkg::FKD_RESP_OKAY : fkd_pkg::FKD_RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // configuration register write
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fn_q <= fkd_pkg::FKD_FN_RESET_VAL;
            lockout_q <= 1'b0;
            heat_cool_q <= 1'b0;
        end else if (do_write && aw_addr_q == fkd_pkg::FKD_CFG_ADDR && w_strb_q[0]) begin
            // codes past the table fall back to off
            fn_q <= (w_data_q[fkd_pkg::FKD_CFG_FN_LSB +: 4] > 4'(fkd_pkg::FKD_FN_DIGIT_SHIFT)) ?
                fkd_pkg::FKD_FN_OFF : fkd_pkg::fkd_fn_t'(w_data_q[fkd_pkg::FKD_CFG_FN_LSB +: 4]);
            lockout_q <= w_data_q[fkd_pkg::FKD_CFG_LOCK_BIT];
            heat_cool_q <= w_data_q[fkd_pkg::FKD_CFG_HC_BIT];
        end
    end

    // read data mux
    function automatic logic [31:0] rd_word(input logic [7:0] a, input logic [31:0] cfg, input logic [31:0] st);
        unique case (a)
            fkd_pkg::FKD_CFG_ADDR: rd_word = cfg;
            fkd_pkg::FKD_STAT_ADDR: rd_word = st;
            default: rd_word = 32'h0;
        endcase
    endfunction

    logic [31:0] cfg_word;
    logic [31:0] st_word;
    always_comb begin
        cfg_word = 32'h0;
        cfg_word[fkd_pkg::FKD_CFG_FN_LSB +: 4] = fn_q;
        cfg_word[fkd_pkg::FKD_CFG_LOCK_BIT] = lockout_q;
        cfg_word[fkd_pkg::FKD_CFG_HC_BIT] = heat_cool_q;
        st_word = 32'h0;
        st_word[fkd_pkg::FKD_ST_RUN_BIT] = running_q;
        st_word[fkd_pkg::FKD_ST_HOLD_BIT] = hold_q;
        st_word[fkd_pkg::FKD_ST_MAN_BIT] = manual_q;
        st_word[fkd_pkg::FKD_ST_TUNE_BIT] = tune_q;
        st_word[fkd_pkg::FKD_ST_ITEM_LSB +: 3] = monitor_item;
    end

    // axi4-lite read channel
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0;
            s_rresp <= fkd_pkg::FKD_RESP_OKAY;
        end else begin
            s_arready <= s_arvalid && !s_arready && !s_rvalid;
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rdata <= rd_word(s_araddr, cfg_word, st_word);
                s_rresp <= (s_araddr == fkd_pkg::FKD_CFG_ADDR || s_araddr == fkd_pkg::FKD_STAT_ADDR) ?
                    fkd_pkg::FKD_RESP_OKAY : fkd_pkg::FKD_RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // checks
    sequence s_reset_press;
        fn_q == fkd_pkg::FKD_FN_RESET && key_enabled && function_key_assign && !fired_q;
    endsequence
    AST_OFF_SILENT: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (fn_q == fkd_pkg::FKD_FN_OFF) |=> (act == '0))
        else $error("key action while function off");
    AST_LOCK_SILENT: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        lockout_q |=> (act == '0))
        else $error("key action while locked out");
    AST_RESET_TIME: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        $rose(act.reset) |-> $past(held_q) >= 16'(RESET_TICKS))
        else $error("reset fired before two seconds");
    AST_RUN_TIME: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        $rose(act.run) |-> $past(held_q) >= 16'(RUN_TICKS))
        else $error("run fired before one second");
    AST_RESET_FIRES: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (s_reset_press and reset_due) |=> act.reset)
        else $error("reset not fired when due");
    AST_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        act.hold_toggle |=> !act.hold_toggle [*2])
        else $error("action repeated within one press");
    AST_ITEM_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        monitor_item < fkd_pkg::FKD_ITEM_COUNT)
        else $error("monitor item out of range");
    AST_SHIFT_EDIT: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        act.digit_shift |-> $past(editing))
        else $error("digit shift outside editing");
    AST_PARTIAL_HC: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (heat_cool_q && is_partial(fn_q) && $stable(fn_q)) |=> !act.tune_start && !act.tune_cancel)
        else $error("partial tuning acted under heat-cool");
endmodule
`default_nettype wire

// ---- fkd_key_model.sv ----
`default_nettype none
// operator at the front panel: holds the key down for a chosen number of cycles
module fkd_key_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] len,
    output logic key
);
    timeunit 1ns;
    timeprecision 1ps;
    // cycles left in the current press; zero means the key is up
    logic [7:0] left_q = 8'h00;
    // a new press restarts the count, so both quick taps and long holds are possible
    always_ff @(posedge clk) begin
        if (go) begin
            left_q <= len;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
    // the key is debounced already, so it is a clean level
    assign key = (left_q != 8'h00);
endmodule
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // one press: setting, editing flag, hold cycles, judged bits, expected pulses
    typedef struct packed {
        logic [7:0] cfg;
        logic ed;
        logic [7:0] len;
        logic [11:0] care;
        logic [11:0] exp;
    } fkd_step_t;
    // hold of 1 s is 12 cycles here, 2 s is 24 cycles
    localparam fkd_step_t STEPS [0:22] = '{
        '{8'h0d, 1'b1, 8'd4, 12'hfff, 12'h002},
        '{8'h0d, 1'b0, 8'd4, 12'hfff, 12'h000},
        '{8'h00, 1'b0, 8'd20, 12'hfff, 12'h000},
        '{8'h14, 1'b0, 8'd20, 12'hfff, 12'h000},
        '{8'h04, 1'b0, 8'd4, 12'hfff, 12'h000},
        '{8'h04, 1'b0, 8'd20, 12'hfff, 12'h200},
        '{8'h01, 1'b0, 8'd20, 12'hfff, 12'h800},
        '{8'h03, 1'b0, 8'd16, 12'hfff, 12'h000},
        '{8'h03, 1'b0, 8'd40, 12'hfff, 12'h400},
        '{8'h03, 1'b0, 8'd20, 12'hfff, 12'h800},
        '{8'h02, 1'b0, 8'd16, 12'hfff, 12'h000},
        '{8'h02, 1'b0, 8'd40, 12'hfff, 12'h400},
        '{8'h05, 1'b0, 8'd20, 12'hfff, 12'h100},
        '{8'h06, 1'b0, 8'd20, 12'hfff, 12'h080},
        '{8'h09, 1'b0, 8'd20, 12'h0c0, 12'h040},
        '{8'h08, 1'b0, 8'd20, 12'hfff, 12'h0a0},
        '{8'h08, 1'b0, 8'd20, 12'h0c0, 12'h040},
        '{8'h07, 1'b0, 8'd20, 12'hfff, 12'h090},
        '{8'h07, 1'b0, 8'd20, 12'h0c0, 12'h040},
        '{8'h27, 1'b0, 8'd20, 12'hfff, 12'h000},
        '{8'h29, 1'b0, 8'd20, 12'hfff, 12'h000},
        '{8'h0a, 1'b0, 8'd20, 12'hfff, 12'h008},
        '{8'h0b, 1'b0, 8'd20, 12'hfff, 12'h004}
    };
    logic ref_clk, rst_n, key, go, editing;
    logic [7:0] len, s_awaddr, s_araddr;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [31:0] s_wdata, s_rdata, rd_data;
    logic [1:0] s_bresp, s_rresp, rd_resp;
    logic [2:0] monitor_item;
    fkd_pkg::fkd_act_t act;
    int miscompares = 0;
    int compares = 0;
    // short tick and hold counts keep each press to a few dozen cycles
    fkd_function_key_dispatch #(.TICK_CYCLES(4), .RUN_TICKS(3), .RESET_TICKS(6)) u_fkd_function_key_dispatch (
        .ref_clk(ref_clk), .rst_n(rst_n), .function_key_assign(key), .editing(editing),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .act(act), .monitor_item(monitor_item)
    );
    fkd_key_model u_fkd_key_model (.clk(ref_clk), .go(go), .len(len), .key(key));
    // compare and count
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask
    // bus write: address and data offered together, each dropped once taken
    // waits as long as the slave needs; only the watchdog ends a hang
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wready === 1'b1) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        s_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_bresp});
        @(posedge ref_clk);
    endtask
    // bus read: result left in rd_data and rd_resp
    task automatic rd(input logic [7:0] a);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_arready === 1'b1) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1);
        s_rready <= 1'b0;
        rd_data = s_rdata;
        rd_resp = s_rresp;
        @(posedge ref_clk);
    endtask
    // select a function, press, and gather every pulse until well after release
    task automatic press(input fkd_step_t s);
        fkd_pkg::fkd_act_t seen;
        int n;
        seen = '0;
        n = 0;
        wr(fkd_pkg::FKD_CFG_ADDR, {24'h0, s.cfg});
        editing <= s.ed;
        len <= s.len;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (int'(s.len) + 12) begin
            @(posedge ref_clk);
            seen = seen | act;
            if (act != '0) n++;
        end
        chk("act", {20'h0, s.exp}, {20'h0, seen & s.care});
        chk("pulses", {31'h0, s.exp != 12'h0}, n);
    endtask
    // single place where the run ends
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // all presses take under 3000 cycles; this limit leaves wide margin
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
    initial begin
        {rst_n, go, editing, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {len, s_awaddr, s_araddr, s_wdata} = '0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(fkd_pkg::FKD_CFG_ADDR);
        chk("cfg reset", 32'h0000000d, rd_data);
        rd(8'h0c);
        chk("unmapped resp", 32'h2, {30'h0, rd_resp});
        chk("unmapped data", 32'h0, rd_data);
        foreach (STEPS[k]) press(STEPS[k]);
        // run then reset left it in reset; hold and manual each inverted once; tuning cancelled
        rd(fkd_pkg::FKD_STAT_ADDR);
        chk("status", 32'h6, rd_data);
        // software reports tuning done, so the next press starts again instead of cancelling
        press('{8'h06, 1'b0, 8'd20, 12'hfff, 12'h080});
        wr(fkd_pkg::FKD_CMD_ADDR, 32'h1);
        press('{8'h06, 1'b0, 8'd20, 12'hfff, 12'h080});
        wr(8'h0c, 32'h0, 2'h2);
        rd(fkd_pkg::FKD_STAT_ADDR);
        chk("status tuning", 32'he, rd_data);
        // five slots, wrapping back to the first
        for (int i = 1; i <= 5; i++) begin
            press('{8'h0c, 1'b0, 8'd4, 12'hfff, 12'h001});
            chk("item", i % 5, {29'h0, monitor_item});
        end
        stop_test();
    end
endmodule
`default_nettype wire
